// ==== shared/sps_map.svh ====
// Clock rates, field positions and timing counts of the serial port block.
// Included by the design; holds definitions only.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_CLK_KHZ      50000
`define SPS_MAX_RATE_KHZ 16000
`define SPS_MIN_RATE_KHZ 125
`define SPS_MIN_HALF     ((`SPS_CLK_KHZ + 2 * `SPS_MAX_RATE_KHZ - 1) / (2 * `SPS_MAX_RATE_KHZ))
`define SPS_MAX_HALF     (`SPS_CLK_KHZ / (2 * `SPS_MIN_RATE_KHZ))
`define SPS_FIFO_DEPTH   255
`define SPS_SLV_BITS     8
`define SPS_F_RXNE       0
`define SPS_F_TXE        1
`define SPS_F_RXTH       2
`define SPS_F_TXTH       3
`define SPS_F_TXOVF      4
`define SPS_F_RXUDF      5
`define SPS_F_TXUDF      6
`define SPS_F_TMO        7
`endif

// ==== shared/sps_pkg.sv ====
// Types of the serial port block: configuration carriers and the state record.
// Assumes sps_map.svh for the numeric constants.
package sps_pkg;
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_TAIL} sps_mst_t;
  typedef struct packed {
    logic       enable;
    logic       cpol;
    logic       cpha;
    logic       lsb_first;
    logic       manual;
    logic       sel_hold;
    logic [1:0] sel_num;
    logic [4:0] len;
    logic [7:0] half;
  } sps_mcfg_t;
  typedef struct packed {
    logic        lsb_first;
    logic [7:0]  rx_thresh;
    logic [7:0]  tx_thresh;
    logic [15:0] timeout;
    logic [7:0]  irq_mask;
  } sps_scfg_t;
  typedef struct packed {
    sps_mst_t    mst;
    logic [7:0]  div;
    logic [5:0]  edge_k;
    logic [4:0]  idx;
    logic [4:0]  len;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] m_rx;
    logic        sclk;
    logic        mosi;
    logic        m_oe;
    logic [2:0]  sel;
    logic        m_done;
    logic        m_irq;
    logic        busy;
    logic        s_prev_clk;
    logic        s_prev_sel;
    logic [7:0]  s_shin;
    logic [7:0]  s_shout;
    logic [2:0]  s_bits;
    logic        s_miso;
    logic        s_miso_oe;
    logic [7:0]  tx_wp;
    logic [7:0]  tx_rp;
    logic [7:0]  tx_cnt;
    logic [7:0]  rx_wp;
    logic [7:0]  rx_rp;
    logic [7:0]  rx_cnt;
    logic [7:0]  s_rx_byte;
    logic [7:0]  s_flags;
    logic        s_irq;
    logic [15:0] tmo;
  } sps_state_t;
endpackage : sps_pkg

// ==== src/sps_top.sv ====
// Serial port block: a 1 to 32 bit master in four clock modes and an 8-bit mode 0 slave.
// Assumes all pins are synchronous to core_clk and pull-ups sit outside the block.
`timescale 1ns/1ns
`include "sps_map.svh"
module sps_top (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Master control and status
  input  wire sps_pkg::sps_mcfg_t m_cfg,
  input  wire logic              m_start,
  input  wire logic [31:0]       m_tx_data,
  input  wire logic              m_irq_en,
  input  wire logic              m_done_clr,
  output logic [31:0]            m_rx_data,
  output logic                   m_busy,
  output logic                   m_done,
  output logic                   m_irq,
  // Master pins
  output logic                   master_serial_clock,
  output logic                   master_serial_clock_oe,
  output logic                   master_data_out,
  output logic                   master_data_out_oe,
  input  wire logic              master_data_in,
  output logic                   first_select,
  output logic                   second_select,
  output logic                   third_select,
  output logic                   select_oe,
  // Slave control and status
  input  wire sps_pkg::sps_scfg_t s_cfg,
  input  wire logic              s_tx_wr,
  input  wire logic [7:0]        s_tx_byte,
  input  wire logic              s_rx_rd,
  input  wire logic [7:0]        s_irq_clr,
  output logic [7:0]             s_rx_byte,
  output logic [7:0]             s_tx_level,
  output logic [7:0]             s_rx_level,
  output logic [7:0]             s_flags,
  output logic                   s_irq,
  // Slave pins
  input  wire logic              slave_side_clock,
  input  wire logic              slave_side_data_in,
  input  wire logic              slave_side_select,
  output logic                   slave_side_data_out,
  output logic                   slave_side_data_out_oe
);
  import sps_pkg::*;

  function automatic logic [4:0] sps_step(input logic lsb, input logic [4:0] i);
    sps_step = lsb ? 5'(i + 5'h01) : 5'(i - 5'h01);
  endfunction : sps_step

  function automatic logic sps_first(input logic lsb, input logic [7:0] b);
    sps_first = lsb ? b[0] : b[7];
  endfunction : sps_first

  function automatic logic [7:0] sps_count(input logic [7:0] c, input logic up,
                                           input logic dn);
    sps_count = 8'(c + {7'h00, up} - {7'h00, dn});
  endfunction : sps_count

  sps_state_t st_reg;
  sps_state_t st_next;
  logic [7:0] tx_mem [0:255];
  logic [7:0] rx_mem [0:255];
  logic [7:0] half;
  logic       tick;
  logic       lead;
  logic       samp;
  logic [4:0] nidx;
  logic       s_rise;
  logic       s_fall;
  logic       s_act;
  logic       s_selfall;
  logic [7:0] shin_new;
  logic       tx_wr_ok;
  logic       tx_pop;
  logic       rx_push;
  logic       rx_pop;
  logic [7:0] fset;

  always_comb begin
    st_next = st_reg;
    // Clamping keeps the bit rate inside the supported band whatever software asks.
    if (m_cfg.half < 8'(`SPS_MIN_HALF)) begin
      half = 8'(`SPS_MIN_HALF);
    end else if (m_cfg.half > 8'(`SPS_MAX_HALF)) begin
      half = 8'(`SPS_MAX_HALF);
    end else begin
      half = m_cfg.half;
    end
    tick = (st_reg.div <= 8'h01);
    lead = ~st_reg.edge_k[0];
    samp = lead ^ m_cfg.cpha;
    nidx = sps_step(m_cfg.lsb_first, st_reg.idx);
    st_next.m_oe = m_cfg.enable;
    if (st_reg.mst != M_IDLE) begin
      st_next.div = tick ? half : 8'(st_reg.div - 8'h01);
    end
    case (st_reg.mst)
      M_IDLE: begin
        st_next.sclk = m_cfg.cpol;
        if (m_start && m_cfg.enable) begin
          st_next.mst    = M_RUN;
          st_next.busy   = 1'b1;
          st_next.div    = half;
          st_next.edge_k = 6'h00;
          st_next.len    = m_cfg.len;
          st_next.tx     = m_tx_data;
          st_next.rx     = 32'h0000_0000;
          st_next.idx    = m_cfg.lsb_first ? 5'h00 : m_cfg.len;
          st_next.mosi   = m_cfg.lsb_first ? m_tx_data[0] : m_tx_data[m_cfg.len];
        end
      end
      M_RUN: begin
        if (tick) begin
          st_next.sclk   = ~st_reg.sclk;
          st_next.edge_k = 6'(st_reg.edge_k + 6'h01);
          if (samp) begin
            st_next.rx[st_reg.idx] = master_data_in;
          end
          if (!lead) begin
            st_next.idx = nidx;
            if (!m_cfg.cpha) begin
              st_next.mosi = st_reg.tx[nidx];
            end
          end else if (m_cfg.cpha) begin
            st_next.mosi = st_reg.tx[st_reg.idx];
          end
          if (st_reg.edge_k == {st_reg.len, 1'b1}) begin
            st_next.mst = M_TAIL;
          end
        end
      end
      M_TAIL: begin
        if (tick) begin
          st_next.mst  = M_IDLE;
          st_next.busy = 1'b0;
          st_next.m_rx = st_reg.rx;
        end
      end
      default: st_next.mst = M_IDLE;
    endcase
    // The done flag is sticky; a completion in the clearing cycle wins.
    st_next.m_done = (st_reg.m_done & ~m_done_clr) |
                     (st_reg.mst == M_TAIL && tick);
    st_next.m_irq = st_next.m_done & m_irq_en;
    if (m_cfg.manual) begin
      st_next.sel = m_cfg.sel_hold ? ~(3'h1 << m_cfg.sel_num) : 3'h7;
    end else begin
      st_next.sel = (st_next.mst != M_IDLE) ? ~(3'h1 << m_cfg.sel_num) : 3'h7;
    end

    // Slave side.
    s_act     = ~slave_side_select;
    s_rise    = slave_side_clock & ~st_reg.s_prev_clk;
    s_fall    = ~slave_side_clock & st_reg.s_prev_clk;
    s_selfall = ~slave_side_select & st_reg.s_prev_sel;
    st_next.s_prev_clk = slave_side_clock;
    st_next.s_prev_sel = slave_side_select;
    st_next.s_miso_oe  = s_act;
    shin_new = s_cfg.lsb_first ? {slave_side_data_in, st_reg.s_shin[7:1]}
                               : {st_reg.s_shin[6:0], slave_side_data_in};
    tx_wr_ok = s_tx_wr && (st_reg.tx_cnt != 8'(`SPS_FIFO_DEPTH));
    tx_pop   = s_selfall && (st_reg.tx_cnt != 8'h00);
    rx_push  = 1'b0;
    rx_pop   = s_rx_rd && (st_reg.rx_cnt != 8'h00);
    fset     = 8'h00;
    if (s_selfall) begin
      // An empty transmit FIFO sends zeros rather than stale data.
      st_next.s_bits  = 3'h0;
      st_next.s_shout = tx_pop ? tx_mem[st_reg.tx_rp] : 8'h00;
      st_next.s_miso  = tx_pop ? sps_first(s_cfg.lsb_first, tx_mem[st_reg.tx_rp]) : 1'b0;
      fset[`SPS_F_TXUDF] = ~tx_pop;
    end else if (s_act && s_rise) begin
      st_next.s_shin = shin_new;
      st_next.s_bits = 3'(st_reg.s_bits + 3'h1);
      rx_push = (st_reg.s_bits == 3'(`SPS_SLV_BITS - 1)) &&
                (st_reg.rx_cnt != 8'(`SPS_FIFO_DEPTH));
    end else if (s_act && s_fall) begin
      st_next.s_shout = s_cfg.lsb_first ? {1'b0, st_reg.s_shout[7:1]}
                                        : {st_reg.s_shout[6:0], 1'b0};
      st_next.s_miso  = sps_first(s_cfg.lsb_first, st_next.s_shout);
    end
    if (tx_wr_ok) st_next.tx_wp = 8'(st_reg.tx_wp + 8'h01);
    if (tx_pop) st_next.tx_rp = 8'(st_reg.tx_rp + 8'h01);
    if (rx_push) st_next.rx_wp = 8'(st_reg.rx_wp + 8'h01);
    if (rx_pop) begin
      st_next.rx_rp     = 8'(st_reg.rx_rp + 8'h01);
      st_next.s_rx_byte = rx_mem[st_reg.rx_rp];
    end
    st_next.tx_cnt = sps_count(st_reg.tx_cnt, tx_wr_ok, tx_pop);
    st_next.rx_cnt = sps_count(st_reg.rx_cnt, rx_push, rx_pop);
    if (rx_push || st_reg.rx_cnt == 8'h00) begin
      st_next.tmo = 16'h0000;
    end else if (st_reg.tmo != s_cfg.timeout) begin
      st_next.tmo = 16'(st_reg.tmo + 16'h0001);
    end
    fset[`SPS_F_RXNE]  = st_reg.rx_cnt != 8'h00;
    fset[`SPS_F_TXE]   = st_reg.tx_cnt == 8'h00;
    fset[`SPS_F_RXTH]  = st_reg.rx_cnt > s_cfg.rx_thresh;
    fset[`SPS_F_TXTH]  = st_reg.tx_cnt < s_cfg.tx_thresh;
    fset[`SPS_F_TXOVF] = s_tx_wr && !tx_wr_ok;
    fset[`SPS_F_RXUDF] = s_rx_rd && !rx_pop;
    fset[`SPS_F_TMO]   = (s_cfg.timeout != 16'h0000) && (st_next.tmo == s_cfg.timeout) &&
                         (st_reg.tmo != s_cfg.timeout);
    st_next.s_flags = (st_reg.s_flags & ~s_irq_clr) | fset;
    st_next.s_irq   = |(st_next.s_flags & s_cfg.irq_mask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg            <= '0;
      st_reg.sel        <= 3'h7;
      st_reg.s_prev_sel <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // The FIFO arrays carry no reset; only the pointers and counts need one.
  always_ff @(posedge core_clk) begin
    if (tx_wr_ok) begin
      tx_mem[st_reg.tx_wp] <= s_tx_byte;
    end
    if (rx_push) begin
      rx_mem[st_reg.rx_wp] <= shin_new;
    end
  end

  assign m_rx_data              = st_reg.m_rx;
  assign m_busy                 = st_reg.busy;
  assign m_done                 = st_reg.m_done;
  assign m_irq                  = st_reg.m_irq;
  assign master_serial_clock    = st_reg.sclk;
  assign master_serial_clock_oe = st_reg.m_oe;
  assign master_data_out        = st_reg.mosi;
  assign master_data_out_oe     = st_reg.m_oe;
  assign first_select           = st_reg.sel[0];
  assign second_select          = st_reg.sel[1];
  assign third_select           = st_reg.sel[2];
  assign select_oe              = st_reg.m_oe;
  assign s_rx_byte              = st_reg.s_rx_byte;
  assign s_tx_level             = st_reg.tx_cnt;
  assign s_rx_level             = st_reg.rx_cnt;
  assign s_flags                = st_reg.s_flags;
  assign s_irq                  = st_reg.s_irq;
  assign slave_side_data_out    = st_reg.s_miso;
  assign slave_side_data_out_oe = st_reg.s_miso_oe;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [6:0] chk_edges;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chk_edges <= 7'h00;
    end else if (st_reg.mst == M_IDLE) begin
      chk_edges <= 7'h00;
    end else if (master_serial_clock != st_next.sclk) begin
      chk_edges <= 7'(chk_edges + 7'h01);
    end
  end

  sequence s_tail_end;
    st_reg.mst == M_TAIL && tick;
  endsequence

  a_edge_total: assert property (s_tail_end |->
    chk_edges == 7'({st_reg.len, 1'b0} + 7'h02)) else $error("edge count wrong");
  a_done_flag: assert property (s_tail_end |=> m_done && m_rx_data == $past(st_reg.rx))
    else $error("done flag or data missing");
  a_clock_idle: assert property (st_reg.mst == M_IDLE && !m_start |=>
    master_serial_clock == $past(m_cfg.cpol)) else $error("clock not at idle level");
  a_phase0_change: assert property (st_reg.mst == M_RUN && !m_cfg.cpha &&
    $changed(master_data_out) |-> master_serial_clock == m_cfg.cpol)
    else $error("data moved on leading edge");
  a_pins_undriven: assert property (!m_cfg.enable |=> !master_serial_clock_oe &&
    !master_data_out_oe && !select_oe) else $error("master pins driven while off");
  a_auto_release: assert property ((!m_cfg.manual and s_tail_end) |=>
    {third_select, second_select, first_select} == 3'h7) else $error("select kept");
  a_first_select: assert property (m_cfg.manual && m_cfg.sel_hold &&
    m_cfg.sel_num == 2'h0 |=> !first_select && second_select) else $error("bad select");
  a_tx_overflow: assert property (s_tx_wr && s_tx_level == 8'(`SPS_FIFO_DEPTH) |=>
    s_flags[`SPS_F_TXOVF] && s_tx_level == $past(s_tx_level)) else $error("overflow lost");
  a_rx_underflow: assert property (s_rx_rd && s_rx_level == 8'h00 |=>
    s_flags[`SPS_F_RXUDF]) else $error("underflow lost");
  a_slave_quiet: assert property (slave_side_select |=>
    !slave_side_data_out_oe) else $error("slave drives while deselected");
endmodule : sps_top

// ==== test/sps_slv_model.sv ====
// Behavioural slave chip for the master side of the serial port block.
// Assumes the bench feeds it the resolved pin levels and the clock mode in use.
`timescale 1ns/1ns
module sps_slv_model (
  // Pins
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        sel_n,
  output logic             miso,
  // Mode, reply word and captured bits
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [31:0] reply,
  output logic [31:0]      got
);
  logic [31:0] sh_reg;
  // Deselected, the line floats up to its pull-up.
  initial miso = 1'b1;
  always @(posedge sel_n) miso = 1'b1;
  always @(negedge sel_n) begin
    sh_reg = reply;
    got = 32'h0;
    if (!cpha) begin
      miso = sh_reg[31];
      sh_reg = sh_reg << 1;
    end
  end
  always @(sclk) begin
    if (!sel_n) begin
      if ((sclk != cpol) == cpha) begin
        miso = sh_reg[31];
        sh_reg = sh_reg << 1;
      end else begin
        got = {got[30:0], mosi};
      end
    end
  end
endmodule : sps_slv_model

// ==== test/spi_master_slave_port_tb.sv ====
// Self-checking bench of the serial port block, master and slave sides.
// Assumes sps_pkg, sps_map.svh and the slave chip model are compiled first.
`timescale 1ns/1ns
`include "sps_map.svh"
module spi_master_slave_port_tb;
  import sps_pkg::*;
  sps_mcfg_t   mc;
  sps_scfg_t   sc;
  logic        core_clk, nrst, m_start, m_irq_en, m_done_clr, s_tx_wr, s_rx_rd;
  logic [31:0] m_tx, m_rx, reply, got, rnd;
  logic        m_busy, m_done, m_irq, mck, mck_oe, mdo, mdo_oe, mdi, sel0, sel1, sel2, sel_oe;
  logic [7:0]  s_txb, s_clr, s_rxb, s_txl, s_rxl, s_flags, q;
  logic        s_irq, ssclk, sdi, ssel, sdo, sdo_oe;
  int          n_mismatch, checks_done, pos;
  byte unsigned txq[$], rxq[$];
  sps_top dut_u (.core_clk(core_clk), .nrst(nrst), .m_cfg(mc), .m_start(m_start),
    .m_tx_data(m_tx), .m_irq_en(m_irq_en), .m_done_clr(m_done_clr), .m_rx_data(m_rx),
    .m_busy(m_busy), .m_done(m_done), .m_irq(m_irq), .master_serial_clock(mck),
    .master_serial_clock_oe(mck_oe), .master_data_out(mdo), .master_data_out_oe(mdo_oe),
    .master_data_in(mdi), .first_select(sel0), .second_select(sel1), .third_select(sel2),
    .select_oe(sel_oe), .s_cfg(sc), .s_tx_wr(s_tx_wr), .s_tx_byte(s_txb), .s_rx_rd(s_rx_rd),
    .s_irq_clr(s_clr), .s_rx_byte(s_rxb), .s_tx_level(s_txl), .s_rx_level(s_rxl),
    .s_flags(s_flags), .s_irq(s_irq), .slave_side_clock(ssclk), .slave_side_data_in(sdi),
    .slave_side_select(ssel), .slave_side_data_out(sdo), .slave_side_data_out_oe(sdo_oe));
  // Undriven master pins sit at their pull-up level.
  sps_slv_model chip_u (.sclk(mck_oe ? mck : 1'b1), .mosi(mdo_oe ? mdo : 1'b1),
    .sel_n(sel_oe ? (sel0 & sel1 & sel2) : 1'b1), .miso(mdi), .cpol(mc.cpol),
    .cpha(mc.cpha), .reply(reply), .got(got));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic mxfer();
    int k, ln, h;
    logic [31:0] ex, et, sx;
    ln = mc.len;
    h = mc.half < `SPS_MIN_HALF ? `SPS_MIN_HALF : mc.half;
    h = h > `SPS_MAX_HALF ? `SPS_MAX_HALF : h;
    m_tx = xs();
    ex = 32'h0;
    et = 32'h0;
    for (int j = 0; j <= ln; j++) begin
      // Once the reply word is used up the slave chip shifts out zeros.
      ex[mc.lsb_first ? j : ln - j] = (pos + j < 32) ? reply[31 - pos - j] : 1'b0;
      et[ln - j] = m_tx[mc.lsb_first ? j : ln - j];
    end
    sx = ~(32'h1 << mc.sel_num) & 32'h7;
    m_start = 1'b1;
    cyc(1);
    m_start = 1'b0;
    k = 1;
    chk("select", sx, {sel2, sel1, sel0});
    chk("busy", 1, m_busy);
    while (m_done !== 1'b1 && k < 20000) begin
      cyc(1);
      k++;
    end
    chk("latency", (2 * ln + 3) * h + 1, k);
    chk("rx word", ex, m_rx);
    chk("tx bits", et, got & (32'hffffffff >> (31 - ln)));
    chk("select after", mc.manual ? sx : 32'h7, {sel2, sel1, sel0});
    chk("busy after", 0, m_busy);
    cyc(1);
    chk("irq", m_irq_en, m_irq);
    m_done_clr = 1'b1;
    cyc(1);
    m_done_clr = 1'b0;
    cyc(1);
    chk("done clear", 0, m_done);
    pos += ln + 1;
  endtask : mxfer
  task automatic push(input logic [7:0] v);
    s_txb = v;
    s_tx_wr = 1'b1;
    cyc(1);
    s_tx_wr = 1'b0;
    cyc(1);
    if (txq.size() < 255) txq.push_back(v);
  endtask : push
  task automatic pop(output logic [7:0] v);
    s_rx_rd = 1'b1;
    cyc(1);
    s_rx_rd = 1'b0;
    v = s_rxb;
    cyc(1);
  endtask : pop
  task automatic sbyte(input logic [7:0] d, output logic [7:0] v);
    ssel = 1'b0;
    cyc(3);
    chk("slave oe", 1, sdo_oe);
    for (int i = 0; i < 8; i++) begin
      sdi = d[sc.lsb_first ? i : 7 - i];
      cyc(3);
      v[sc.lsb_first ? i : 7 - i] = sdo;
      ssclk = 1'b1;
      cyc(3);
      ssclk = 1'b0;
      cyc(3);
    end
    ssel = 1'b1;
    cyc(4);
    rxq.push_back(d);
  endtask : sbyte
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    rnd = 32'h63598faa;
    {mc, sc, m_start, m_irq_en, m_done_clr, s_tx_wr, s_rx_rd, m_tx, s_txb, s_clr} = '0;
    {ssclk, sdi, reply, pos} = '0;
    ssel = 1'b1;
    nrst = 1'b0;
    cyc(5);
    chk("oe in reset", 0, {mck_oe, mdo_oe, sel_oe});
    nrst = 1'b1;
    cyc(2);
    m_start = 1'b1;
    cyc(1);
    m_start = 1'b0;
    cyc(4);
    chk("disabled", 0, {m_busy, mck_oe, mdo_oe, sel_oe});
    for (int i = 0; i < 12; i++) begin
      mc = '{enable: 1'b1, cpol: i[1], cpha: i[0], lsb_first: i[2] ^ i[3],
             sel_num: 2'(i % 3), len: 5'(xs()), half: 8'(xs() % 4 + 2), default: '0};
      if (i < 2) mc.len = i ? 5'h1f : 5'h00;
      if (i == 2) mc.half = 8'hff;
      if (i == 3) mc.half = 8'h01;
      m_irq_en = xs() % 2;
      reply = xs();
      pos = 0;
      cyc(2);
      mxfer();
    end
    mc.manual = 1'b1;
    mc.sel_hold = 1'b1;
    mc.sel_num = 2'h0;
    cyc(3);
    pos = 0;
    mxfer();
    mc.len = 5'h0f;
    mxfer();
    mc.sel_hold = 1'b0;
    cyc(2);
    chk("manual release", 7, {sel2, sel1, sel0});
    sc = '{rx_thresh: 8'h01, tx_thresh: 8'h02, default: '0};
    for (int l = 0; l < 2; l++) begin
      sc.lsb_first = l[0];
      for (int b = 0; b < 3; b++) push(xs());
      for (int b = 0; b < 3; b++) begin
        sbyte(xs(), q);
        chk("slave out", txq.pop_front(), q);
      end
      chk("tx empty", 1, s_flags[1]);
      chk("levels", 2'b11, s_flags[3:2]);
      for (int b = 0; b < 3; b++) begin
        pop(q);
        chk("slave in", rxq.pop_front(), q);
      end
    end
    s_clr = 8'hff;
    cyc(1);
    s_clr = 8'h00;
    repeat (8) begin
      ssclk = ~ssclk;
      cyc(3);
    end
    chk("no select", 0, s_rxl);
    sbyte(8'ha5, q);
    chk("tx underflow", {8'h00, 1'b1}, {q, s_flags[6]});
    pop(q);
    chk("slave in", rxq.pop_front(), q);
    pop(q);
    chk("rx underflow", 1, s_flags[5]);
    sc.timeout = 16'd40;
    sc.irq_mask = 8'h80;
    s_clr = 8'hff;
    cyc(1);
    s_clr = 8'h00;
    sbyte(8'h3c, q);
    cyc(2);
    chk("rx waiting", {1'b1, 1'b0, 1'b0}, {s_flags[0], s_flags[7], s_irq});
    cyc(60);
    chk("time-out", {1'b1, 1'b1}, {s_flags[7], s_irq});
    repeat (256) push(xs());
    chk("tx full", {8'd255, 1'b1}, {s_txl, s_flags[4]});
    summarize();
  end
endmodule : spi_master_slave_port_tb
